/* core/misc_control_pkg.sv */
// Constants shared by the platform control register bank.
// Assumes a 32-bit APB slave port with a 12-bit byte address.
package misc_control_pkg;

    // Bus geometry.
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Register indexes as printed; the byte address is four times the index.
    localparam logic [11:0] SLAVE_PRESENCE_IDX  = 12'h008;
    localparam logic [11:0] MASTER_PRESENCE_IDX = 12'h00A;
    localparam logic [11:0] CONTROL_WORD_IDX    = 12'h00C;
    localparam logic [11:0] COMPUTE_OP_IDX      = 12'h040;

    // Byte addresses derived from the indexes.
    localparam logic [11:0] SLAVE_PRESENCE_ADDR  = {SLAVE_PRESENCE_IDX[9:0], 2'b00};
    localparam logic [11:0] MASTER_PRESENCE_ADDR = {MASTER_PRESENCE_IDX[9:0], 2'b00};
    localparam logic [11:0] CONTROL_WORD_ADDR    = {CONTROL_WORD_IDX[9:0], 2'b00};
    localparam logic [11:0] COMPUTE_OP_ADDR      = {COMPUTE_OP_IDX[9:0], 2'b00};

    // Read-only connection bitmaps (fixed by the crossbar build).
    localparam logic [15:0] SLAVE_PRESENCE_RST  = 16'h0007;
    localparam logic [15:0] MASTER_PRESENCE_RST = 16'h000D;

    // Reset values of the writable registers.
    localparam logic [31:0] CONTROL_WORD_RST = 32'h0000_0000;
    localparam logic [31:0] COMPUTE_OP_RST   = 32'h0000_0000;

    // Control word field positions.
    localparam int STALL_BIT        = 16;
    localparam int SPEC_OFF_BIT     = 15;
    localparam int DATA_SPEC_BIT    = 14;
    localparam int CACHE_OFF_BIT    = 13;
    localparam int INSTR_CACHE_BIT  = 12;
    localparam int DATA_CACHE_BIT   = 11;
    localparam int CACHE_CLEAR_BIT  = 10;
    localparam int ROUND_ROBIN_BIT  = 9;

    // Bits of the control word that hold state; the clear strobe is not one.
    localparam logic [31:0] CONTROL_WR_MASK = 32'h0001_FA00;

    // Compute operation register field positions.
    localparam int REQUEST_BIT = 0;
    localparam int ACK_BIT     = 1;
    localparam int WAKE_BIT    = 2;

    // Byte lanes of the fields that a write must enable.
    localparam int CONTROL_LOW_LANE  = 1;
    localparam int CONTROL_HIGH_LANE = 2;
    localparam int COMPUTE_OP_LANE   = 0;

endpackage

/* core/compute_op_ctrl.sv */
// Compute operation request and wake-on-interrupt state.
// Assumes write strobes come from the APB slave in the register bank.
`timescale 1ns/100ps
module compute_op_ctrl (
    // Clock and reset.
    input  wire logic clock,
    input  wire logic rst,
    // Software write of the compute operation register.
    input  wire logic write_en,
    input  wire logic write_request,
    input  wire logic write_wake,
    // Vector fetch seen by the core, one-cycle pulse.
    input  wire logic vector_fetch,
    // Stored bits.
    output logic      compute_op_request,
    output logic      wake_on_interrupt
);
    import misc_control_pkg::*;

    logic next_compute_op_request;  // Next request bit.
    logic next_wake_on_interrupt;   // Next wake option bit.

    // Software sets or withdraws the request; a wake fetch clears it.
    always_comb begin
        next_compute_op_request = compute_op_request;
        next_wake_on_interrupt  = wake_on_interrupt;
        if (write_en) begin
            next_compute_op_request = write_request;
            next_wake_on_interrupt  = write_wake;
        end
        // The wake clear wins over a same-cycle software write.
        if (vector_fetch && wake_on_interrupt) begin
            next_compute_op_request = 1'b0;
        end
    end

    // Register the state.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            compute_op_request <= COMPUTE_OP_RST[REQUEST_BIT];
            wake_on_interrupt  <= COMPUTE_OP_RST[WAKE_BIT];
        end else begin
            compute_op_request <= next_compute_op_request;
            wake_on_interrupt  <= next_wake_on_interrupt;
        end
    end

endmodule

/* core/platform_misc_control_regs.sv */
// Platform control register bank on APB.
// Assumes an APB master on clock; all inputs are synchronous to clock.
//
// Contract
// - Slave bitmap read-only, upper zero, 0007h.
// - Master bitmap read-only, upper zero, 000Dh.
// - Bit 16 enables flash-busy stalling.
// - Bit 15 kills speculation; bit 14 adds data.
// - Reset: speculation for instructions only.
// - Bit 13 kills cache; 12, 11 per type.
// - Reset: cache on for both fetch types.
// - Bit 10 write-one clears cache, reads zero.
// - Bit 9 selects round-robin over fixed priority.
// - Request bit written by software, hardware-cleared.
// - Wake bit lets vector fetch clear request.
// - Ack bit shows compute operation entered.
`timescale 1ns/100ps
module platform_misc_control_regs (
    // Clock and reset.
    input  wire logic                               clock,
    input  wire logic                               rst,
    // APB slave port.
    input  wire logic                               psel,
    input  wire logic                               penable,
    input  wire logic                               pwrite,
    input  wire logic [misc_control_pkg::ADDR_W-1:0] paddr,
    input  wire logic [misc_control_pkg::DATA_W-1:0] pwdata,
    input  wire logic [3:0]                         pstrb,
    output logic      [misc_control_pkg::DATA_W-1:0] prdata,
    output logic                                    pready,
    output logic                                    pslverr,
    // Core and low-power sequencer status.
    input  wire logic                               vector_fetch,
    input  wire logic                               compute_op_ack_in,
    // Flash controller controls.
    output logic                                    flash_busy_stall_en,
    output logic                                    spec_instr_en,
    output logic                                    spec_data_en,
    output logic                                    cache_instr_en,
    output logic                                    cache_data_en,
    output logic                                    flash_cache_clear,
    // Crossbar and low-power controls.
    output logic                                    round_robin_select,
    output logic                                    compute_op_request
);
    import misc_control_pkg::*;

    // Register select codes for the address decoder.
    typedef enum {
        SEL_NONE,
        SEL_SLAVE,
        SEL_MASTER,
        SEL_CONTROL,
        SEL_COMPUTE
    } reg_sel_t;

    // Flash policy outputs in a fixed order.
    typedef struct packed {
        logic stall;
        logic spec_instr;
        logic spec_data;
        logic cache_instr;
        logic cache_data;
    } flash_policy_t;

    // Decodes a byte address into a register select.
    function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
        case (addr)
            SLAVE_PRESENCE_ADDR:  decode = SEL_SLAVE;
            MASTER_PRESENCE_ADDR: decode = SEL_MASTER;
            CONTROL_WORD_ADDR:    decode = SEL_CONTROL;
            COMPUTE_OP_ADDR:      decode = SEL_COMPUTE;
            default:              decode = SEL_NONE;
        endcase
    endfunction

    // Turns the control word into the flash controller enables.
    function automatic flash_policy_t policy(input logic [31:0] word);
        flash_policy_t p;
        p.stall       = word[STALL_BIT];
        p.spec_instr  = ~word[SPEC_OFF_BIT];
        p.spec_data   = ~word[SPEC_OFF_BIT] & word[DATA_SPEC_BIT];
        p.cache_instr = ~word[CACHE_OFF_BIT] & ~word[INSTR_CACHE_BIT];
        p.cache_data  = ~word[CACHE_OFF_BIT] & ~word[DATA_CACHE_BIT];
        policy = p;
    endfunction

    // Reset value of the enables, taken from the control word reset.
    localparam flash_policy_t POLICY_RST = policy(CONTROL_WORD_RST);

    // Bus phase decode.
    reg_sel_t      sel;             // Register addressed by paddr.
    logic          setup_phase;     // First cycle of a transfer.
    logic          access_done;     // Edge at which a transfer completes.
    logic          write_done;      // Completing write to a mapped register.
    logic [31:0]   lane_mask;       // Byte enables widened to bits.
    logic [31:0]   read_word;       // Read data for the addressed register.

    // Stored state and next values.
    logic [31:0]   control_word;            // Writable control word bits.
    logic [31:0]   next_control_word;       // Next control word.
    logic          ack_seen;                // Registered acknowledge status.
    logic          wake_on_interrupt;       // Wake option from the submodule.
    logic          compute_write;           // Write strobe for compute register.
    logic          cache_clear_hit;         // Write of one to the clear strobe.
    flash_policy_t next_policy;             // Enables from the next control word.
    logic [31:0]   next_prdata;             // Next read data.
    logic          next_pready;             // Next ready.
    logic          next_pslverr;            // Next error flag.

    // Widen each byte enable over its eight data bits.
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++) begin : g_lane
            assign lane_mask[lane*8 +: 8] = {8{pstrb[lane]}};
        end
    endgenerate

    // Transfer phases; the slave always answers after one wait-free access.
    always_comb begin
        sel         = decode(paddr);
        setup_phase = psel & ~penable;
        access_done = psel & penable & pready;
        write_done  = access_done & pwrite & (sel != SEL_NONE);
    end

    // Read multiplexer; reserved bits read as zero.
    always_comb begin
        read_word = 32'h0000_0000;
        case (sel)
            SEL_SLAVE: begin
                read_word = {16'h0000, 8'h00, SLAVE_PRESENCE_RST[7:0]};
            end
            SEL_MASTER: begin
                read_word = {16'h0000, 8'h00, MASTER_PRESENCE_RST[7:0]};
            end
            SEL_CONTROL: begin
                // The clear strobe holds no state and so reads as zero.
                read_word = control_word & CONTROL_WR_MASK;
            end
            SEL_COMPUTE: begin
                read_word[REQUEST_BIT] = compute_op_request;
                read_word[ACK_BIT]     = ack_seen;
                read_word[WAKE_BIT]    = wake_on_interrupt;
            end
            default: begin
                read_word = 32'h0000_0000;
            end
        endcase
    end

    // Control word update, byte lanes honoured, reserved bits kept at zero.
    always_comb begin
        next_control_word = control_word;
        cache_clear_hit   = 1'b0;
        if (write_done && (sel == SEL_CONTROL)) begin
            next_control_word = ((pwdata & lane_mask) | (control_word & ~lane_mask))
                                & CONTROL_WR_MASK;
            cache_clear_hit   = pstrb[CONTROL_LOW_LANE] & pwdata[CACHE_CLEAR_BIT];
        end
        next_policy = policy(next_control_word);
    end

    // Compute register write, only when its byte lane is enabled.
    always_comb begin
        compute_write = write_done & (sel == SEL_COMPUTE) & pstrb[COMPUTE_OP_LANE];
    end

    // APB answer: ready in the cycle after setup, data and error with it.
    always_comb begin
        next_pready  = setup_phase;
        next_pslverr = setup_phase & (decode(paddr) == SEL_NONE);
        next_prdata  = prdata;
        if (setup_phase) begin
            next_prdata = pwrite ? 32'h0000_0000 : read_word;
        end
    end

    // Control state and flash enables; the enables follow the stored word.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            control_word        <= CONTROL_WORD_RST;
            // Speculation for instructions only, cache on for both.
            flash_busy_stall_en <= POLICY_RST.stall;
            spec_instr_en       <= POLICY_RST.spec_instr;
            spec_data_en        <= POLICY_RST.spec_data;
            cache_instr_en      <= POLICY_RST.cache_instr;
            cache_data_en       <= POLICY_RST.cache_data;
            round_robin_select  <= CONTROL_WORD_RST[ROUND_ROBIN_BIT];
            flash_cache_clear   <= 1'b0;
        end else begin
            control_word        <= next_control_word;
            flash_busy_stall_en <= next_policy.stall;
            spec_instr_en       <= next_policy.spec_instr;
            spec_data_en        <= next_policy.spec_data;
            cache_instr_en      <= next_policy.cache_instr;
            cache_data_en       <= next_policy.cache_data;
            round_robin_select  <= next_control_word[ROUND_ROBIN_BIT];
            // One-cycle invalidate pulse for the flash cache.
            flash_cache_clear   <= cache_clear_hit;
        end
    end

    // Bus answer registers.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Acknowledge follows the sequencer; writes never reach it.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ack_seen <= COMPUTE_OP_RST[ACK_BIT];
        end else begin
            ack_seen <= compute_op_ack_in;
        end
    end

    // Request and wake option live in their own small unit.
    compute_op_ctrl u_compute_op (
        .clock              (clock),
        .rst                (rst),
        .write_en           (compute_write),
        .write_request      (pwdata[REQUEST_BIT]),
        .write_wake         (pwdata[WAKE_BIT]),
        .vector_fetch       (vector_fetch),
        .compute_op_request (compute_op_request),
        .wake_on_interrupt  (wake_on_interrupt)
    );

endmodule

/* test/misc_control_monitor.sv */
// Concurrent checks on the ports of the platform control register bank.
// Assumes an APB master that holds each request until pready is sampled high.
`timescale 1ns/100ps
module misc_control_monitor (
    // Clock and reset.
    input wire logic                                clock,
    input wire logic                                rst,
    // APB slave port.
    input wire logic                                psel,
    input wire logic                                penable,
    input wire logic                                pwrite,
    input wire logic [misc_control_pkg::ADDR_W-1:0] paddr,
    input wire logic [misc_control_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0]                          pstrb,
    input wire logic [misc_control_pkg::DATA_W-1:0] prdata,
    input wire logic                                pready,
    input wire logic                                pslverr,
    // Status and controls.
    input wire logic                                vector_fetch,
    input wire logic                                compute_op_ack_in,
    input wire logic                                flash_busy_stall_en,
    input wire logic                                spec_instr_en,
    input wire logic                                spec_data_en,
    input wire logic                                cache_instr_en,
    input wire logic                                cache_data_en,
    input wire logic                                flash_cache_clear,
    input wire logic                                round_robin_select,
    input wire logic                                compute_op_request
);
    import misc_control_pkg::*;
    logic wr_ctrl;   // Completing write of the control word.
    logic wr_compute; // Completing write of the compute register.
    logic rd_done;   // Completing read of any place.
    logic mapped;    // Address hits a register.
    logic wake_q;    // Shadow of the stored wake bit.
    logic next_wake; // Next value of the shadow.
    assign wr_ctrl = psel && penable && pready && pwrite && (paddr == CONTROL_WORD_ADDR);
    assign wr_compute = psel && penable && pready && pwrite && (paddr == COMPUTE_OP_ADDR);
    assign rd_done = psel && penable && pready && !pwrite;
    assign mapped  = paddr inside {SLAVE_PRESENCE_ADDR, MASTER_PRESENCE_ADDR, CONTROL_WORD_ADDR, COMPUTE_OP_ADDR};
    // The shadow follows lane 0 writes, since the wake bit is not at the ports.
    always_comb begin
        next_wake = (wr_compute && pstrb[0]) ? pwdata[2] : wake_q;
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= next_wake;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    ready_one_cycle_a: assert property (psel && !penable |=> pready ##1 !pready) else $error("pready not one cycle");
    slave_map_a: assert property (rd_done && paddr == SLAVE_PRESENCE_ADDR |-> prdata == 32'h0000_0007 && !pslverr)
        else $error("slave bitmap wrong");
    master_map_a: assert property (rd_done && paddr == MASTER_PRESENCE_ADDR |-> prdata == 32'h0000_000D)
        else $error("master bitmap wrong");
    unmapped_err_a: assert property (pready && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    stall_track_a: assert property (wr_ctrl && pstrb[2] |=> flash_busy_stall_en == $past(pwdata[16]))
        else $error("stall enable not written");
    spec_map_a: assert property (wr_ctrl && pstrb[1] |=> spec_instr_en == !$past(pwdata[15])
        && spec_data_en == ($past(pwdata[14]) && !$past(pwdata[15]))) else $error("speculation map wrong");
    cache_map_a: assert property (wr_ctrl && pstrb[1] |=> cache_data_en == !($past(pwdata[13]) || $past(pwdata[11]))
        && cache_instr_en == !($past(pwdata[13]) || $past(pwdata[12]))) else $error("cache map wrong");
    clear_pulse_a: assert property (wr_ctrl && pstrb[1] && pwdata[10] |=> flash_cache_clear ##1 !flash_cache_clear)
        else $error("clear pulse wrong");
    clear_cause_a: assert property ($rose(flash_cache_clear) |-> $past(wr_ctrl && pstrb[1] && pwdata[10]))
        else $error("clear pulse without cause");
    rr_select_a: assert property (wr_ctrl && pstrb[1] |=> round_robin_select == $past(pwdata[9]))
        else $error("arbitration select not written");
    wake_clear_a: assert property (vector_fetch && wake_q |=> !compute_op_request) else $error("request not cleared");
    req_hold_a: assert property (!vector_fetch && !wr_compute |=> $stable(compute_op_request))
        else $error("request changed unprompted");
    compute_readback_a: assert property (rd_done && paddr == COMPUTE_OP_ADDR |-> prdata[31:3] == 29'h0
        && prdata[2] == wake_q) else $error("compute register readback wrong");
    // Read data is taken at the setup edge from the one-flop copy of the acknowledge.
    ack_read_a: assert property (rd_done && paddr == COMPUTE_OP_ADDR |-> prdata[1] == $past(compute_op_ack_in, 2))
        else $error("acknowledge readback wrong");
endmodule

/* test/tb_platform_misc_control_regs.sv */
// Self-checking bench for the platform control register bank.
// Assumes the design answers APB with pready one cycle after setup.
`timescale 1ns/100ps
module tb_platform_misc_control_regs;
    import misc_control_pkg::*;
    typedef struct packed {logic [31:0] d; logic e; logic rd;} note_t;
    logic        clock, rst, psel, penable, pwrite, vector_fetch, compute_op_ack_in, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, ctrl_m;
    logic [3:0]  pstrb;
    logic        flash_busy_stall_en, spec_instr_en, spec_data_en, cache_instr_en, cache_data_en;
    logic        flash_cache_clear, round_robin_select, compute_op_request, req_m, wake_m, ack_m, clr_pend;
    int          miscompares, cmp_count;
    note_t       exp_q[$];
    platform_misc_control_regs u_platform_misc_control_regs (.clock(clock), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .vector_fetch(vector_fetch), .compute_op_ack_in(compute_op_ack_in),
        .flash_busy_stall_en(flash_busy_stall_en), .spec_instr_en(spec_instr_en), .spec_data_en(spec_data_en),
        .cache_instr_en(cache_instr_en), .cache_data_en(cache_data_en), .flash_cache_clear(flash_cache_clear),
        .round_robin_select(round_robin_select), .compute_op_request(compute_op_request));
    // Free-running 100 MHz clock.
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task summarize;
        $display("Counts: %0d miscompares, %0d comparisons", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task mism(input string m);
        $display("[ERR] %0t %s", $time, m);
        miscompares++;
    endtask
    task cmp_bus(input note_t n);
        cmp_count++;
        if (pslverr !== n.e || (n.rd && prdata !== n.d)) mism("bus response differs");
    endtask
    // Compares the level outputs with the model of the stored bits.
    task chk_out;
        logic [6:0] e;
        e = {ctrl_m[16], !ctrl_m[15], !ctrl_m[15] && ctrl_m[14], !(ctrl_m[13] || ctrl_m[12]),
             !(ctrl_m[13] || ctrl_m[11]), ctrl_m[9], req_m};
        cmp_count++;
        if ({flash_busy_stall_en, spec_instr_en, spec_data_en, cache_instr_en, cache_data_en,
             round_robin_select, compute_op_request} !== e) mism("control outputs differ");
    endtask
    // One APB transfer; the request is left up so a setup may follow at once.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
             input logic [31:0] ed, input logic ee);
        int n;
        exp_q.push_back('{d: ed, e: ee, rd: !w});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            mism("no ready");
            summarize();
        end
    endtask
    task idle;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    // Control write on the given lanes, then a back-to-back readback.
    task wctrl(input logic [31:0] d, input logic [3:0] s);
        logic [31:0] m;
        m = (s[1] ? 32'h0000_FA00 : 32'h0) | (s[2] ? 32'h0001_0000 : 32'h0);
        ctrl_m = (ctrl_m & ~m) | (d & m);
        apb(1'b1, CONTROL_WORD_ADDR, d, s, 32'h0, 1'b0);
        apb(1'b0, CONTROL_WORD_ADDR, 32'h0, 4'h0, ctrl_m, 1'b0);
        idle;
        chk_out;
    endtask
    // Compute write with the ack and reserved bits set, then readback.
    task wcpo(input logic rq, input logic wk);
        req_m = rq;
        wake_m = wk;
        apb(1'b1, COMPUTE_OP_ADDR, {29'h1FFF_FFFF, wk, 1'b1, rq}, 4'hF, 32'h0, 1'b0);
        apb(1'b0, COMPUTE_OP_ADDR, 32'h0, 4'h0, {29'h0, wake_m, ack_m, req_m}, 1'b0);
        idle;
    endtask
    task vfetch;
        vector_fetch <= 1'b1;
        @(posedge clock);
        vector_fetch <= 1'b0;
        @(posedge clock);
        if (wake_m) req_m = 1'b0;
        chk_out;
    endtask
    // Result watcher: takes the oldest note at each answer, and tracks the clear pulse.
    always @(posedge clock) begin
        if (!rst && pready === 1'b1) begin
            if (exp_q.size() == 0) mism("unexpected ready");
            else cmp_bus(exp_q.pop_front());
        end
        if (!rst) begin
            cmp_count++;
            if (flash_cache_clear !== clr_pend) mism("clear pulse differs");
        end
        clr_pend = !rst && pready === 1'b1 && pwrite && paddr == CONTROL_WORD_ADDR && pstrb[1] && pwdata[10];
    end
    initial begin
        {psel, penable, pwrite, vector_fetch, compute_op_ack_in, req_m, wake_m, ack_m, clr_pend} = 9'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        ctrl_m = 32'h0;
        rst = 1'b1;
        void'($urandom(32'h2D8D9D3B));
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk_out;
        apb(1'b0, SLAVE_PRESENCE_ADDR, 32'h0, 4'h0, 32'h0000_0007, 1'b0);
        apb(1'b1, SLAVE_PRESENCE_ADDR, 32'hFFFF_FFFF, 4'hF, 32'h0, 1'b0);
        apb(1'b0, SLAVE_PRESENCE_ADDR, 32'h0, 4'h0, 32'h0000_0007, 1'b0);
        apb(1'b0, MASTER_PRESENCE_ADDR, 32'h0, 4'h0, 32'h0000_000D, 1'b0);
        apb(1'b1, MASTER_PRESENCE_ADDR, 32'hFFFF_FFFF, 4'hF, 32'h0, 1'b0);
        apb(1'b0, MASTER_PRESENCE_ADDR, 32'h0, 4'h0, 32'h0000_000D, 1'b0);
        apb(1'b0, CONTROL_WORD_ADDR, 32'h0, 4'h0, 32'h0, 1'b0);
        apb(1'b0, COMPUTE_OP_ADDR, 32'h0, 4'h0, 32'h0, 1'b0);
        apb(1'b1, 12'h024, 32'hFFFF_FFFF, 4'hF, 32'h0, 1'b1);
        apb(1'b0, 12'h024, 32'h0, 4'h0, 32'h0, 1'b1);
        idle;
        wctrl(32'hFFFF_FFFF, 4'hF);
        wctrl(32'h0, 4'hF);
        for (int i = 0; i < 40; i++) wctrl($urandom, 4'($urandom));
        // A reset in mid-run must bring back the reset policy from any random state.
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        ctrl_m = 32'h0;
        @(posedge clock);
        chk_out;
        apb(1'b0, CONTROL_WORD_ADDR, 32'h0, 4'h0, 32'h0, 1'b0);
        idle;
        wcpo(1'b1, 1'b0);
        vfetch;
        wcpo(1'b1, 1'b1);
        vfetch;
        wcpo(1'b1, 1'b0);
        // A write without lane 0 must leave the request standing.
        apb(1'b1, COMPUTE_OP_ADDR, 32'h0, 4'hE, 32'h0, 1'b0);
        idle;
        chk_out;
        wcpo(1'b0, 1'b0);
        compute_op_ack_in <= 1'b1;
        ack_m = 1'b1;
        idle;
        idle;
        wcpo(1'b1, 1'b1);
        compute_op_ack_in <= 1'b0;
        ack_m = 1'b0;
        idle;
        idle;
        wcpo(1'b0, 1'b0);
        chk_out;
        summarize();
    end
endmodule
bind platform_misc_control_regs misc_control_monitor u_misc_control_monitor (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .vector_fetch(vector_fetch), .compute_op_ack_in(compute_op_ack_in),
    .flash_busy_stall_en(flash_busy_stall_en), .spec_instr_en(spec_instr_en), .spec_data_en(spec_data_en),
    .cache_instr_en(cache_instr_en), .cache_data_en(cache_data_en), .flash_cache_clear(flash_cache_clear),
    .round_robin_select(round_robin_select), .compute_op_request(compute_op_request));
